// ===== dasp_cfg_if.sv
`timescale 1ns/10ps
`default_nettype none
interface dasp_cfg_if;
    import dasp_pkg::*;
    logic [7:0] mode;
    logic [7:0] baud;
    logic       tx_load;
    logic [7:0] tx_data;
    logic       tx_busy;
    logic       rx_done;
    logic [7:0] rx_data;
    logic [2:0] rx_err;
    logic       rx_line;
    logic       tx_line;
    modport top (output mode, output baud, output tx_load, output tx_data, output rx_line,
                 input tx_busy, input rx_done, input rx_data, input rx_err, input tx_line);
    modport chan (input mode, input baud, input tx_load, input tx_data, input rx_line,
                  output tx_busy, output rx_done, output rx_data, output rx_err,
                  output tx_line);
endinterface : dasp_cfg_if
`default_nettype wire

// ===== dasp_chan.sv
`timescale 1ns/10ps
`default_nettype none
module dasp_chan
    import dasp_pkg::*;
#(
    parameter bit IR_OK = 1'b0
) (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    dasp_cfg_if.chan  cfg
);
    typedef struct packed {
        logic [7:0]  bdiv;
        dasp_state_e ts;
        logic [3:0]  tovs;
        logic [2:0]  tbit;
        logic [7:0]  tsh;
        logic        tpar;
        logic        tline;
        dasp_state_e rs;
        logic [3:0]  rovs;
        logic [2:0]  rbit;
        logic [7:0]  rsh;
        logic        rpar;
        logic        rprev;
        logic        rdone;
        logic [7:0]  rdata;
        logic [2:0]  rerr;
    } dasp_chan_s;

    dasp_chan_s s_q, s_d;
    logic tick, txe, rxe, irda, cl8, sl2, rx_in, tx_bit;
    logic [1:0] ps;

    assign txe  = cfg.mode[MODE_TXE_BIT];
    assign rxe  = cfg.mode[MODE_RXE_BIT];
    assign ps   = cfg.mode[MODE_PS_HI:MODE_PS_LO];
    assign cl8  = cfg.mode[MODE_CL_BIT];
    assign sl2  = cfg.mode[MODE_SL_BIT];
    assign irda = IR_OK & cfg.mode[MODE_IRDA_BIT];
    assign tick = (s_q.bdiv == cfg.baud);
    // Infrared: receive pulse high means a zero bit
    assign rx_in = irda ? ~cfg.rx_line : cfg.rx_line;

    always_comb begin
        s_d = s_q;
        s_d.rdone = 1'b0;
        s_d.bdiv = tick ? 8'h00 : s_q.bdiv + 8'h01;
        if (!txe) begin
            s_d.ts    = DASP_IDLE;
            s_d.tline = 1'b1;
        end else if (cfg.tx_load && s_q.ts == DASP_IDLE) begin
            s_d.tsh  = cl8 ? cfg.tx_data : {1'b0, cfg.tx_data[6:0]};
            s_d.tpar = (ps == PAR_ODD);
            s_d.ts   = DASP_START;
            s_d.tovs = 4'h0;
        end else if (tick && s_q.ts != DASP_IDLE) begin
            s_d.tovs = s_q.tovs + 4'h1;
            if (s_q.tovs == OVS_LAST) begin
                case (s_q.ts)
                    DASP_START: begin
                        s_d.ts   = DASP_DATA;
                        s_d.tbit = 3'h0;
                    end
                    DASP_DATA: begin
                        s_d.tsh  = {1'b0, s_q.tsh[7:1]};
                        s_d.tpar = s_q.tpar ^ s_q.tsh[0];
                        s_d.tbit = s_q.tbit + 3'h1;
                        if (s_q.tbit == (cl8 ? 3'h7 : 3'h6)) begin
                            s_d.ts = (ps == PAR_NONE) ? DASP_STOP : DASP_PAR;
                        end
                    end
                    DASP_PAR:  s_d.ts = DASP_STOP;
                    DASP_STOP: s_d.ts = sl2 ? DASP_STOP2 : DASP_IDLE;
                    default:   s_d.ts = DASP_IDLE;
                endcase
            end
        end
        case (s_q.ts)
            DASP_START: tx_bit = 1'b0;
            DASP_DATA:  tx_bit = s_q.tsh[0];
            DASP_PAR:   tx_bit = (ps == PAR_ZERO) ? 1'b0 : s_q.tpar;
            default:    tx_bit = 1'b1;
        endcase
        if (txe) begin
            // Infrared: short high pulse for each zero bit
            s_d.tline = irda ? (~tx_bit & (s_q.tovs < IR_PULSE_END)) : tx_bit;
        end
        s_d.rprev = rx_in;
        if (!rxe) begin
            s_d.rs = DASP_IDLE;
        end else begin
            case (s_q.rs)
                DASP_IDLE: begin
                    if (s_q.rprev && !rx_in) begin
                        s_d.rs   = DASP_START;
                        s_d.rovs = 4'h0;
                    end
                end
                default: begin
                    if (tick) begin
                        s_d.rovs = s_q.rovs + 4'h1;
                        if (s_q.rovs == OVS_MID) begin
                            case (s_q.rs)
                                DASP_START: begin
                                    s_d.rs   = rx_in ? DASP_IDLE : DASP_DATA;
                                    s_d.rbit = 3'h0;
                                    s_d.rpar = (ps == PAR_ODD);
                                    s_d.rsh  = 8'h00;
                                end
                                DASP_DATA: begin
                                    s_d.rsh  = cl8 ? {rx_in, s_q.rsh[7:1]}
                                                   : {1'b0, rx_in, s_q.rsh[6:1]};
                                    s_d.rpar = s_q.rpar ^ rx_in;
                                    s_d.rbit = s_q.rbit + 3'h1;
                                    if (s_q.rbit == (cl8 ? 3'h7 : 3'h6)) begin
                                        s_d.rs = (ps == PAR_NONE) ? DASP_STOP : DASP_PAR;
                                    end
                                end
                                DASP_PAR: begin
                                    s_d.rpar = s_q.rpar ^ rx_in;
                                    s_d.rs   = DASP_STOP;
                                end
                                default: begin
                                    s_d.rs    = DASP_IDLE;
                                    s_d.rdone = 1'b1;
                                    s_d.rdata = s_q.rsh;
                                    s_d.rerr  = 3'h0;
                                    s_d.rerr[STAT_FE_BIT] = ~rx_in;
                                    s_d.rerr[STAT_PE_BIT] = ps[1] & s_q.rpar;
                                end
                            endcase
                        end
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_q       <= '0;
            s_q.ts    <= DASP_IDLE;
            s_q.rs    <= DASP_IDLE;
            s_q.tline <= 1'b1;
            s_q.rprev <= 1'b1;
            s_q.rdata <= RX_BUF_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign cfg.tx_busy = (s_q.ts != DASP_IDLE);
    assign cfg.rx_done = s_q.rdone;
    assign cfg.rx_data = s_q.rdata;
    assign cfg.rx_err  = s_q.rerr;
    assign cfg.tx_line = s_q.tline;
endmodule : dasp_chan
`default_nettype wire

// ===== dasp_peer.sv
`timescale 1ns/10ps
`default_nettype none
module dasp_peer (
    input  wire logic clk_i,
    input  wire logic txd_i,
    output var  logic rxd_o
);
    localparam int BT = 16;
    initial rxd_o = 1'b1;
    // Start bit, then n bits lsb first, idle high
    task automatic send(input logic [11:0] d, input int n);
        rxd_o <= 1'b0;
        repeat (BT) @(negedge clk_i);
        for (int i = 0; i < n; i++) begin
            rxd_o <= d[i];
            repeat (BT) @(negedge clk_i);
        end
        rxd_o <= 1'b1;
    endtask : send
    // Centre sampling of n bits after a start bit
    task automatic grab(output logic [11:0] d, input int n);
        d = 12'hfff;
        wait (txd_i === 1'b0);
        repeat (BT / 2) @(posedge clk_i);
        for (int i = 0; i < n; i++) begin
            repeat (BT) @(posedge clk_i);
            d[i] = txd_i;
        end
    endtask : grab
endmodule : dasp_peer
`default_nettype wire

// ===== dasp_pkg.sv
`default_nettype none
package dasp_pkg;
    // Register indices within the bus window
    localparam logic [3:0] MODE0_OFS   = 4'h0;
    localparam logic [3:0] STAT0_OFS   = 4'h1;
    localparam logic [3:0] DATA0_OFS   = 4'h2;
    localparam logic [3:0] BAUD0_OFS   = 4'h3;
    localparam logic [3:0] MODE1_OFS   = 4'h8;
    localparam logic [3:0] STAT1_OFS   = 4'h9;
    localparam logic [3:0] DATA1_OFS   = 4'ha;
    localparam logic [3:0] BAUD1_OFS   = 4'hb;
    // Mode register field positions
    localparam int MODE_TXE_BIT  = 7;
    localparam int MODE_RXE_BIT  = 6;
    localparam int MODE_PS_HI    = 5;
    localparam int MODE_PS_LO    = 4;
    localparam int MODE_CL_BIT   = 3;
    localparam int MODE_SL_BIT   = 2;
    localparam int MODE_ISRM_BIT = 1;
    localparam int MODE_IRDA_BIT = 0;
    // Status field positions
    localparam int STAT_PE_BIT   = 2;
    localparam int STAT_FE_BIT   = 1;
    localparam int STAT_OVE_BIT  = 0;
    // Reset values
    localparam logic [7:0] TX_SHIFT_RST = 8'hff;
    localparam logic [7:0] RX_BUF_RST   = 8'hff;
    localparam logic [7:0] MODE_RST     = 8'h00;
    localparam logic [7:0] STAT_RST     = 8'h00;
    localparam logic [7:0] BAUD_RST     = 8'h00;
    // Timing: 16 baud ticks per bit, centre sample at tick 7
    localparam logic [3:0] OVS_LAST     = 4'hf;
    localparam logic [3:0] OVS_MID      = 4'h7;
    localparam logic [3:0] IR_PULSE_END = 4'h2;
    localparam logic [1:0] PAR_NONE     = 2'b00;
    localparam logic [1:0] PAR_ZERO     = 2'b01;
    localparam logic [1:0] PAR_ODD      = 2'b10;
    localparam logic [1:0] PAR_EVEN     = 2'b11;
    typedef enum logic [2:0] {DASP_IDLE, DASP_START, DASP_DATA, DASP_PAR, DASP_STOP,
                              DASP_STOP2} dasp_state_e;
endpackage : dasp_pkg
`default_nettype wire

// ===== dasp_props.sv
`timescale 1ns/10ps
`default_nettype none
module dasp_props
    import dasp_pkg::*;
(
    input wire logic       CLK_I,
    input wire logic       RST_B_I,
    input wire logic [3:0] ADDR_I,
    input wire logic       WR_I,
    input wire logic       RD_I,
    input wire logic [7:0] WMASK_I,
    input wire logic [7:0] WDATA_I,
    input wire logic [7:0] RDATA_O,
    input wire logic       RXD_A_I,
    input wire logic       RXD_B_I,
    input wire logic       TXD_A_O,
    input wire logic       TXD_B_O,
    input wire logic       RX_DONE_IRQ_A_O,
    input wire logic       RX_DONE_IRQ_B_O
);
    logic [7:0] ma_q;
    logic [7:0] mb_q;
    // Shadow of both mode registers
    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            ma_q <= MODE_RST;
            mb_q <= MODE_RST;
        end else if (WR_I && ADDR_I == MODE0_OFS) begin
            ma_q <= (ma_q & ~WMASK_I) | (WDATA_I & WMASK_I);
        end else if (WR_I && ADDR_I == MODE1_OFS) begin
            mb_q <= (mb_q & ~WMASK_I) | (WDATA_I & WMASK_I);
        end
    end
    ////////////////////////////////////////////////////////////////
    default clocking @(posedge CLK_I); endclocking
    default disable iff (!RST_B_I);
    a_stop_idle_a: assert property (!ma_q[MODE_TXE_BIT] && !ma_q[0] && !$past(ma_q[MODE_TXE_BIT])
        && !$past(ma_q[0]) |-> TXD_A_O)
        else $error("line A active while stopped");
    a_stop_idle_b: assert property (!mb_q[MODE_TXE_BIT] && !$past(mb_q[MODE_TXE_BIT])
        |-> TXD_B_O)
        else $error("line B active while stopped");
    a_write_starts_tx: assert property (WR_I && ADDR_I == DATA0_OFS && ma_q[7] && !ma_q[0]
        |-> ##[1:3] !TXD_A_O)
        else $error("write did not start frame");
    a_start_bit_low: assert property ($fell(TXD_A_O) && !ma_q[0] |-> !TXD_A_O [*8])
        else $error("start bit too short");
    a_read_data_holds: assert property (!$past(RD_I) |-> $stable(RDATA_O))
        else $error("read data changed without read");
    a_status_fixed_bits: assert property (RD_I && ADDR_I == STAT0_OFS
        |=> RDATA_O[7:3] == 5'h00 && !RDATA_O[STAT_OVE_BIT])
        else $error("status fixed bits set");
    a_mode_read_back: assert property (RD_I && ADDR_I == MODE0_OFS
        |=> RDATA_O == $past(ma_q))
        else $error("mode read back wrong");
    a_irq_one_pulse: assert property (RX_DONE_IRQ_A_O |=> !RX_DONE_IRQ_A_O)
        else $error("irq longer than one cycle");
    a_irq_rx_enabled: assert property (RX_DONE_IRQ_B_O |-> mb_q[MODE_RXE_BIT])
        else $error("irq with receiver off");
    c_rx_a: cover property (RX_DONE_IRQ_A_O);
    c_tx_b: cover property ($fell(TXD_B_O));
    c_parity_err: cover property (RD_I && ADDR_I == STAT0_OFS ##1 RDATA_O[STAT_PE_BIT]);
endmodule : dasp_props
bind dasp_top dasp_props u_props (.CLK_I(CLK_I), .RST_B_I(RST_B_I), .ADDR_I(ADDR_I),
    .WR_I(WR_I), .RD_I(RD_I), .WMASK_I(WMASK_I), .WDATA_I(WDATA_I), .RDATA_O(RDATA_O),
    .RXD_A_I(RXD_A_I), .RXD_B_I(RXD_B_I), .TXD_A_O(TXD_A_O), .TXD_B_O(TXD_B_O),
    .RX_DONE_IRQ_A_O(RX_DONE_IRQ_A_O), .RX_DONE_IRQ_B_O(RX_DONE_IRQ_B_O));
`default_nettype wire

// ===== dasp_top.sv
`timescale 1ns/10ps
`default_nettype none
module dasp_top
    import dasp_pkg::*;
(
    input  wire logic       CLK_I,
    input  wire logic       RST_B_I,
    input  wire logic [3:0] ADDR_I,
    input  wire logic       WR_I,
    input  wire logic       RD_I,
    input  wire logic [7:0] WMASK_I,
    input  wire logic [7:0] WDATA_I,
    output var  logic [7:0] RDATA_O,
    input  wire logic       RXD_A_I,
    input  wire logic       RXD_B_I,
    output logic            TXD_A_O,
    output logic            TXD_B_O,
    output logic            RX_DONE_IRQ_A_O,
    output logic            RX_DONE_IRQ_B_O
);
    typedef struct packed {
        logic [1:0][7:0] mode;
        logic [1:0][7:0] baud;
        logic [1:0][7:0] stat;
        logic [1:0][7:0] txs;
        logic [1:0][7:0] rxb;
        logic [1:0]      irq;
        logic [1:0]      txl;
        logic [7:0]      rdata;
    } dasp_top_s;

    dasp_top_s s_q, s_d;
    dasp_cfg_if ch_if[2] ();

    ////////////////////////////////////////////////////////////////////////////
    // Channels
    logic [1:0]      done_v, busy_v, txd_v, rxd_v;
    logic [1:0][7:0] rdat_v;
    logic [1:0][2:0] rerr_v;
    assign rxd_v = {RXD_B_I, RXD_A_I};

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign ch_if[c].mode    = s_q.mode[c];
        assign ch_if[c].baud    = s_q.baud[c];
        assign ch_if[c].tx_data = s_q.txs[c];
        // Load one cycle after the write, once the register holds the new byte
        assign ch_if[c].tx_load = s_q.txl[c];
        assign ch_if[c].rx_line = rxd_v[c];
        assign done_v[c] = ch_if[c].rx_done;
        assign busy_v[c] = ch_if[c].tx_busy;
        assign rdat_v[c] = ch_if[c].rx_data;
        assign rerr_v[c] = ch_if[c].rx_err;
        assign txd_v[c]  = ch_if[c].tx_line;
        dasp_chan #(
            .IR_OK (c == 0)
        ) u_chan (
            .clk_i   (CLK_I),
            .rst_b_i (RST_B_I),
            .cfg     (ch_if[c])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register file
    always_comb begin
        s_d = s_q;
        s_d.irq = 2'b00;
        s_d.txl = 2'b00;
        for (int c = 0; c < 2; c++) begin
            if (WR_I) begin
                if (ADDR_I == (c == 0 ? MODE0_OFS : MODE1_OFS)) begin
                    // Bit writes via mask
                    s_d.mode[c] = (s_q.mode[c] & ~WMASK_I) | (WDATA_I & WMASK_I);
                    if (c == 1) begin
                        s_d.mode[c][MODE_ISRM_BIT] = 1'b0;
                        s_d.mode[c][MODE_IRDA_BIT] = 1'b0;
                    end
                end
                if (ADDR_I == (c == 0 ? BAUD0_OFS : BAUD1_OFS)) begin
                    s_d.baud[c] = WDATA_I;
                end
                if (ADDR_I == (c == 0 ? DATA0_OFS : DATA1_OFS)) begin
                    s_d.txs[c] = WDATA_I;
                    s_d.txl[c] = 1'b1;
                end
            end
            if (done_v[c]) begin
                s_d.rxb[c] = rdat_v[c];
                s_d.stat[c] = {5'h00, rerr_v[c]};
                // Overrun flag keeps its previous value; an unread character never sets it
                s_d.stat[c][STAT_OVE_BIT] = s_q.stat[c][STAT_OVE_BIT] | 1'b0;
                if (rerr_v[c] == 3'h0 || !s_q.mode[c][MODE_ISRM_BIT]) begin
                    s_d.irq[c] = 1'b1;
                end
            end
        end
        s_d.rdata = 8'h00;
        case (ADDR_I)
            MODE0_OFS: s_d.rdata = s_q.mode[0];
            MODE1_OFS: s_d.rdata = s_q.mode[1];
            STAT0_OFS: s_d.rdata = s_q.stat[0];
            STAT1_OFS: s_d.rdata = s_q.stat[1];
            DATA0_OFS: s_d.rdata = s_q.rxb[0];
            DATA1_OFS: s_d.rdata = s_q.rxb[1];
            BAUD0_OFS: s_d.rdata = s_q.baud[0];
            BAUD1_OFS: s_d.rdata = s_q.baud[1];
            default:   s_d.rdata = 8'h00;
        endcase
        if (!RD_I) begin
            s_d.rdata = s_q.rdata;
        end
    end

    always_ff @(posedge CLK_I or negedge RST_B_I) begin
        if (!RST_B_I) begin
            s_q.mode  <= {MODE_RST, MODE_RST};
            s_q.baud  <= {BAUD_RST, BAUD_RST};
            s_q.stat  <= {STAT_RST, STAT_RST};
            s_q.txs   <= {TX_SHIFT_RST, TX_SHIFT_RST};
            s_q.rxb   <= {RX_BUF_RST, RX_BUF_RST};
            s_q.irq   <= 2'b00;
            s_q.txl   <= 2'b00;
            s_q.rdata <= 8'h00;
        end else begin
            s_q <= s_d;
        end
    end

    assign RDATA_O         = s_q.rdata;
    assign TXD_A_O         = txd_v[0];
    assign TXD_B_O         = txd_v[1];
    assign RX_DONE_IRQ_A_O = s_q.irq[0];
    assign RX_DONE_IRQ_B_O = s_q.irq[1];
endmodule : dasp_top
`default_nettype wire

// ===== testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
    import dasp_pkg::*;
    logic       clk = 1'b0;
    logic       rst_b = 1'b0;
    logic       wr = 1'b0;
    logic       rd = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [7:0] wmask = 8'hff;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic       rxd_a, rxd_b, txd_a, txd_b, irq_a, irq_b;
    int         n_fail = 0;
    int         n_checks = 0;
    int         n_irq [2] = '{0, 0};
    always #2.5 clk = ~clk;
    always @(posedge clk) begin
        if (irq_a === 1'b1) n_irq[0]++;
        if (irq_b === 1'b1) n_irq[1]++;
    end
    dasp_top dut (.CLK_I(clk), .RST_B_I(rst_b), .ADDR_I(addr), .WR_I(wr), .RD_I(rd),
        .WMASK_I(wmask), .WDATA_I(wdata), .RDATA_O(rdata), .RXD_A_I(rxd_a),
        .RXD_B_I(rxd_b), .TXD_A_O(txd_a), .TXD_B_O(txd_b), .RX_DONE_IRQ_A_O(irq_a),
        .RX_DONE_IRQ_B_O(irq_b));
    dasp_peer pa (.clk_i(clk), .txd_i(txd_a), .rxd_o(rxd_a));
    dasp_peer pb (.clk_i(clk), .txd_i(txd_b), .rxd_o(rxd_b));
    ////////////////////////////////////////////////////////////////
    task automatic chk(input logic [11:0] g, input logic [11:0] e, input string s);
        n_checks++;
        if (g !== e) begin
            n_fail++;
            $display("MISMATCH %0t %s got %h exp %h", $time, s, g, e);
        end
    endtask : chk
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d, input logic [7:0] m = 8'hff);
        @(negedge clk);
        addr = a;
        wdata = d;
        wmask = m;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
    endtask : wr_reg
    task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
        @(negedge clk);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        v = rdata;
    endtask : rd_reg
    // Expected line bits after the start bit; returns their count
    function automatic int fr(input logic [7:0] d, input logic [7:0] m, output logic [11:0] b);
        int   n;
        logic p;
        n = m[MODE_CL_BIT] ? 8 : 7;
        b = 12'hfff;
        for (int i = 0; i < n; i++) b[i] = d[i];
        p = ^d[6:0] ^ (m[MODE_CL_BIT] & d[7]);
        if (m[5:4] != PAR_NONE) begin
            b[n] = (m[5:4] == PAR_ODD) ? ~p : (m[5:4] == PAR_EVEN) ? p : 1'b0;
            n++;
        end
        return n + 1 + int'(m[MODE_SL_BIT]);
    endfunction : fr
    task automatic tx_chk(input int c, input logic [7:0] m, input logic [7:0] d);
        logic [11:0] e, g;
        int          n;
        n = fr(d, m, e);
        wr_reg(4'(c * 8), m);
        fork
            if (c == 0) pa.grab(g, n); else pb.grab(g, n);
            wr_reg(4'(c * 8 + 2), d);
        join
        chk(g, e, "tx frame");
        repeat (16) @(negedge clk);
    endtask : tx_chk
    task automatic rx_chk(input int c, input logic [7:0] m, input logic [7:0] d,
                          input logic [11:0] fl, input logic [7:0] ed, input logic [7:0] es,
                          input int ei);
        logic [11:0] b;
        logic [7:0]  v;
        int          n, k;
        n = fr(d, m, b);
        wr_reg(4'(c * 8), m);
        k = n_irq[c];
        if (c == 0) pa.send(b ^ fl, n); else pb.send(b ^ fl, n);
        repeat (40) @(negedge clk);
        chk(12'(n_irq[c] - k), 12'(ei), "rx irq");
        rd_reg(4'(c * 8 + 2), v);
        chk(12'(v), 12'(ed), "rx data");
        rd_reg(4'(c * 8 + 1), v);
        chk(12'(v), 12'(es), "rx status");
    endtask : rx_chk
    ////////////////////////////////////////////////////////////////
    task automatic t_reset;
        logic [3:0] ra [7] = '{4'h0, 4'h1, 4'h2, 4'h8, 4'h9, 4'ha, 4'h4};
        logic [7:0] re [7] = '{8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'hff, 8'h00};
        logic [7:0] v;
        for (int i = 0; i < 7; i++) begin
            rd_reg(ra[i], v);
            chk(12'(v), 12'(re[i]), "reset value");
        end
    endtask : t_reset
    task automatic t_tx_modes;
        for (int p = 0; p < 4; p++) tx_chk(0, 8'h88 | 8'(p << 4) | (p[0] ? 8'h04 : 8'h00), 8'h96);
        tx_chk(0, 8'ha0, 8'h81);
        tx_chk(1, 8'h8c, 8'h3c);
    endtask : t_tx_modes
    task automatic t_rx_modes;
        rx_chk(0, 8'h78, 8'h5a, 12'h000, 8'h5a, 8'h00, 1);
        rx_chk(0, 8'h78, 8'h5a, 12'h100, 8'h5a, 8'h04, 1);
        rx_chk(0, 8'h7a, 8'ha5, 12'h100, 8'ha5, 8'h04, 0);
        rx_chk(0, 8'h48, 8'hc3, 12'h100, 8'hc3, 8'h02, 1);
        rx_chk(0, 8'h40, 8'hff, 12'h000, 8'h7f, 8'h00, 1);
        rx_chk(0, 8'h58, 8'h11, 12'h100, 8'h11, 8'h00, 1);
        rx_chk(1, 8'h68, 8'h96, 12'h000, 8'h96, 8'h00, 1);
    endtask : t_rx_modes
    task automatic t_regs;
        logic [7:0] v;
        wr_reg(DATA0_OFS, 8'h00);
        rd_reg(DATA0_OFS, v);
        chk(12'(v), 12'h011, "shared address");
        wr_reg(MODE0_OFS, 8'h80, 8'h80);
        wr_reg(MODE0_OFS, 8'h00, 8'h40);
        rd_reg(MODE0_OFS, v);
        chk(12'(v), 12'h098, "bit write");
    endtask : t_regs
    task automatic t_duplex;
        logic [11:0] b, e, g;
        logic [7:0]  v;
        int          n;
        n = fr(8'h3c, 8'hc8, b);
        wr_reg(MODE1_OFS, 8'hc8);
        fork
            pb.send(b, n);
            pb.grab(g, n);
            wr_reg(DATA1_OFS, 8'hc3);
        join
        n = fr(8'hc3, 8'hc8, e);
        chk(g, e, "duplex tx");
        repeat (40) @(negedge clk);
        rd_reg(DATA1_OFS, v);
        chk(12'(v), 12'h03c, "duplex rx");
    endtask : t_duplex
    task automatic t_baud;
        int lows;
        lows = 0;
        wr_reg(BAUD1_OFS, 8'h01);
        wr_reg(MODE1_OFS, 8'h88);
        wr_reg(DATA1_OFS, 8'h00);
        repeat (400) @(negedge clk) lows += int'(!txd_b);
        // Nine low bits of 32 clocks, first may lose one to divider phase
        chk(12'(lows >= 287 && lows <= 288), 12'h001, "divided bit time");
    endtask : t_baud
    task automatic t_ir;
        int         highs;
        logic [7:0] v;
        highs = 0;
        wr_reg(MODE0_OFS, 8'h89);
        wr_reg(DATA0_OFS, 8'h00);
        repeat (250) @(negedge clk) highs += int'(txd_a);
        // Two-clock pulse for each of nine zero bits
        chk(12'(highs), 12'h012, "infrared pulses");
        wr_reg(MODE1_OFS, 8'h03);
        rd_reg(MODE1_OFS, v);
        chk(12'(v), 12'h000, "no infrared on B");
    endtask : t_ir
    task automatic t_stopped_tx;
        int lows;
        lows = 0;
        wr_reg(MODE0_OFS, 8'h00);
        wr_reg(DATA0_OFS, 8'h00);
        repeat (200) @(negedge clk) lows += int'(!txd_a);
        chk(12'(lows), 12'h000, "stopped tx");
    endtask : t_stopped_tx
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : results
    initial begin
        #200000;
        n_fail++;
        results();
    end
    initial begin
        repeat (2) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        rx_chk(0, 8'h00, 8'h5a, 12'h000, 8'hff, 8'h00, 0);
        t_tx_modes();
        t_rx_modes();
        t_regs();
        t_duplex();
        t_baud();
        t_ir();
        t_stopped_tx();
        results();
    end
endmodule : testbench
`default_nettype wire
